// ### common/bird_pkg.sv
package bird_pkg;
    // ------------------------------------------------------------
    // instruction word layout
    // ------------------------------------------------------------
    localparam int unsigned INSN_W    = 14;               // instruction width
    localparam int unsigned PC_W      = 13;               // program counter width
    localparam int unsigned DATA_W    = 8;                // data path width
    localparam int unsigned FADDR_W   = 7;                // file address width
    localparam int unsigned LIT_W     = 11;               // jump literal width
    localparam int unsigned STACK_D   = 8;                // return stack depth
    localparam int unsigned STACK_AW  = 3;                // stack pointer width

    // opcode patterns
    localparam logic [1:0]  JUMP_TOP      = 2'h2;          // top two bits of a jump
    localparam logic [5:0]  INC_OP        = 6'h0a;         // top six bits of increment
    localparam logic [13:0] IRET_WORD     = 14'h0009;      // interrupt return word
    localparam logic [13:0] IDLE_MASK     = 14'h3f9f;      // idle word, care bits
    localparam logic [13:0] IDLE_WORD     = 14'h0000;      // idle word, value

    // field positions
    localparam int unsigned DEST_BIT      = 7;             // destination select bit
    localparam int unsigned LATCH_LO      = 3;             // high-latch bits used
    localparam int unsigned ZERO_BIT      = 2;             // zero flag in status
    localparam int unsigned GLOBAL_EN_BIT = 7;             // enable in interrupt control

    // reset values
    localparam logic [PC_W-1:0]   PC_RST  = 13'h0000;
    localparam logic [DATA_W-1:0] ACC_RST = 8'h00;
    localparam logic [DATA_W-1:0] REG_RST = 8'h00;
    localparam logic [DATA_W-1:0] STATUS_RST = 8'h18;
    localparam logic [DATA_W-1:0] ICTL_RST   = 8'h00;
endpackage

// ### design/branch_increment_return_decode.sv
`timescale 1ns/1ps
`default_nettype none
module branch_increment_return_decode #(
    parameter int unsigned STACK_D = bird_pkg::STACK_D
) (
    input  wire logic                         clk_i,
    input  wire logic                         rst_n_i,
    input  wire logic [bird_pkg::INSN_W-1:0]  insn_i,       // fetched word
    input  wire logic                         insn_valid_i, // word present
    input  wire logic [bird_pkg::DATA_W-1:0]  pc_high_latch_i, // high latch value
    input  wire logic                         push_i,       // interrupt entry push
    input  wire logic [bird_pkg::PC_W-1:0]    push_pc_i,    // address to push
    input  wire logic [bird_pkg::FADDR_W-1:0] peek_addr_i,  // debug file read
    output var  logic [bird_pkg::PC_W-1:0]    pc_o,         // program counter
    output var  logic [bird_pkg::DATA_W-1:0]  acc_o,        // accumulator
    output var  logic [bird_pkg::DATA_W-1:0]  status_o,     // status register
    output var  logic [bird_pkg::DATA_W-1:0]  interrupt_control_reg_o,
    output var  logic                         flush_o,      // pipeline refill cycle
    output var  logic [bird_pkg::DATA_W-1:0]  peek_data_o   // debug file data
);
    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_RUN,        // decode new words
        ST_FLUSH       // idle refill cycle
    } phase_t;

    typedef struct packed {
        phase_t                            phase;
        logic [bird_pkg::PC_W-1:0]         pc;
        logic [bird_pkg::DATA_W-1:0]       acc;
        logic [bird_pkg::DATA_W-1:0]       status;
        logic [bird_pkg::DATA_W-1:0]       ictl;
        logic                              dest;   // latched destination
        logic [bird_pkg::FADDR_W-1:0]      faddr;  // latched file address
        logic [bird_pkg::STACK_AW-1:0]     sp;     // stack pointer
        logic                              flush;
        logic                              wb;     // increment result due
        logic                              fwd;    // operand comes from res
        logic [bird_pkg::DATA_W-1:0]       res;    // last increment result
    } state_t;

    state_t st_ff;                                  // registered state
    state_t nxt_st;                                 // next state
    logic [bird_pkg::PC_W-1:0] stack_ff [STACK_D];  // return stack

    logic [bird_pkg::DATA_W-1:0] file_rd;           // file read data
    logic [bird_pkg::DATA_W-1:0] inc_src;           // increment operand
    logic [bird_pkg::DATA_W-1:0] inc_val;           // incremented value
    logic                        file_we;           // file write strobe
    logic                        do_push;           // stack push
    logic [bird_pkg::DATA_W-1:0] peek_rd;           // second read port

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [bird_pkg::PC_W-1:0] pc_next(
        input logic [bird_pkg::PC_W-1:0] pc);
        pc_next = pc + 13'h0001;
    endfunction

    // top two bits select the absolute jump, the low 11 bits are the literal
    function automatic logic is_jump(input logic [bird_pkg::INSN_W-1:0] w);
        is_jump = (w[bird_pkg::INSN_W-1 -: $bits(bird_pkg::JUMP_TOP)] == bird_pkg::JUMP_TOP);
    endfunction

    // top six bits select the file increment
    function automatic logic is_inc(input logic [bird_pkg::INSN_W-1:0] w);
        is_inc = (w[bird_pkg::INSN_W-1 -: $bits(bird_pkg::INC_OP)] == bird_pkg::INC_OP);
    endfunction

    // idle word with its two don't-care bits masked off
    function automatic logic is_idle(input logic [bird_pkg::INSN_W-1:0] w);
        is_idle = ((w & bird_pkg::IDLE_MASK) == bird_pkg::IDLE_WORD);
    endfunction

    // ------------------------------------------------------------
    // file memory: one port for execution, one for peeking
    // ------------------------------------------------------------
    file_ram #(.AW(bird_pkg::FADDR_W), .DW(bird_pkg::DATA_W)) u_ram (
        .clk_i   (clk_i),
        .raddr_i (insn_i[bird_pkg::FADDR_W-1:0]),
        .rdata_o (file_rd),
        .we_i    (file_we),
        .waddr_i (st_ff.faddr),
        .wdata_i (inc_val)
    );

    file_ram #(.AW(bird_pkg::FADDR_W), .DW(bird_pkg::DATA_W)) u_peek (
        .clk_i   (clk_i),
        .raddr_i (peek_addr_i),
        .rdata_o (peek_rd),
        .we_i    (file_we),
        .waddr_i (st_ff.faddr),
        .wdata_i (inc_val)
    );

    // a back-to-back increment of the same file would read stale ram data:
    // take the result still in flight instead
    assign inc_src = st_ff.fwd ? st_ff.res : file_rd;
    // wrap from all ones to zero falls out of the 8-bit add
    assign inc_val = inc_src + 8'h01;
    // write-back overlaps the next decode, so an increment costs one cycle
    assign file_we = st_ff.wb && st_ff.dest;
    // a push only lands between words, never beside a decode
    assign do_push = push_i && (st_ff.phase == ST_RUN) && !insn_valid_i;

    // ------------------------------------------------------------
    // decode and execute
    // ------------------------------------------------------------
    // one pass: retire any pending increment, then decode the new word
    always_comb begin
        nxt_st       = st_ff;
        nxt_st.flush = 1'b0;
        nxt_st.wb    = 1'b0;
        nxt_st.fwd   = 1'b0;
        // retire the increment decoded on the previous edge, in any phase
        if (st_ff.wb) begin
            if (!st_ff.dest) begin
                // destination bit clear: result goes to the accumulator
                nxt_st.acc = inc_val;
            end
            nxt_st.status[bird_pkg::ZERO_BIT] = (inc_val == 8'h00);
            // kept for a following increment of the same file
            nxt_st.res = inc_val;
        end
        case (st_ff.phase)
            ST_RUN: begin
                if (do_push) begin
                    // interrupt entry stores the return address
                    nxt_st.sp = st_ff.sp + 3'h1;
                end else if (insn_valid_i) begin
                    if (is_jump(insn_i)) begin
                        // flags untouched on a jump
                        nxt_st.pc = {pc_high_latch_i[bird_pkg::LATCH_LO+1:bird_pkg::LATCH_LO],
                                     insn_i[bird_pkg::LIT_W-1:0]};
                        nxt_st.phase = ST_FLUSH;
                        nxt_st.flush = 1'b1;
                    end else if (is_inc(insn_i)) begin
                        // file read issued now, result retired on the next edge
                        nxt_st.wb    = 1'b1;
                        nxt_st.dest  = insn_i[bird_pkg::DEST_BIT];
                        nxt_st.faddr = insn_i[bird_pkg::FADDR_W-1:0];
                        // same file as the write now landing: ram would be stale
                        nxt_st.fwd   = st_ff.wb && st_ff.dest &&
                                       (st_ff.faddr == insn_i[bird_pkg::FADDR_W-1:0]);
                        nxt_st.pc    = pc_next(st_ff.pc);
                    end else if (insn_i == bird_pkg::IRET_WORD) begin
                        nxt_st.sp  = st_ff.sp - 3'h1;
                        nxt_st.pc  = stack_ff[st_ff.sp - 3'h1];
                        nxt_st.ictl[bird_pkg::GLOBAL_EN_BIT] = 1'b1;
                        nxt_st.phase = ST_FLUSH;
                        nxt_st.flush = 1'b1;
                    end else if (is_idle(insn_i)) begin
                        // idle word: only the program counter moves
                        nxt_st.pc = pc_next(st_ff.pc);
                    end else begin
                        // undecoded words are outside this block: step like idle
                        nxt_st.pc = pc_next(st_ff.pc);
                    end
                end
            end
            ST_FLUSH: begin
                // second cycle of a branch does nothing
                nxt_st.phase = ST_RUN;
            end
            default: begin
                nxt_st.phase = ST_RUN;
            end
        endcase
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    // whole state advances together; reset loads constants only
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_ff.phase  <= ST_RUN;
            st_ff.pc     <= bird_pkg::PC_RST;
            st_ff.acc    <= bird_pkg::ACC_RST;
            st_ff.status <= bird_pkg::STATUS_RST;
            st_ff.ictl   <= bird_pkg::ICTL_RST;
            st_ff.dest   <= 1'b0;
            st_ff.faddr  <= 7'h00;
            st_ff.sp     <= 3'h0;
            st_ff.flush  <= 1'b0;
            st_ff.wb     <= 1'b0;
            st_ff.fwd    <= 1'b0;
            st_ff.res    <= bird_pkg::REG_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // return stack storage, no reset needed
    always_ff @(posedge clk_i) begin
        if (do_push) begin
            stack_ff[st_ff.sp] <= push_pc_i;
        end
    end

    // ------------------------------------------------------------
    // outputs straight from flip-flops
    // ------------------------------------------------------------
    // peek data is the mirror ram's registered output
    assign pc_o                    = st_ff.pc;
    assign acc_o                   = st_ff.acc;
    assign status_o                = st_ff.status;
    assign interrupt_control_reg_o = st_ff.ictl;
    assign flush_o                 = st_ff.flush;
    assign peek_data_o             = peek_rd;
endmodule
`default_nettype wire

// ### design/file_ram.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// file register memory, registered read data
// ----------------------------------------------------------------
module file_ram #(
    parameter int unsigned AW = 7,
    parameter int unsigned DW = 8
) (
    input  wire logic          clk_i,
    input  wire logic [AW-1:0] raddr_i,   // read address
    output var  logic [DW-1:0] rdata_o,   // read data, one cycle later
    input  wire logic          we_i,      // write strobe
    input  wire logic [AW-1:0] waddr_i,   // write address
    input  wire logic [DW-1:0] wdata_i    // write data
);
    logic [DW-1:0] mem [0:(1<<AW)-1];    // storage array

    // write and registered read on one edge; a read of the written address gets the old word
    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem[waddr_i] <= wdata_i;
        end
        rdata_o <= mem[raddr_i];
    end
endmodule
`default_nettype wire

// ### tb/decode_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// decode monitor: jump, increment, return and idle timing
// ------------------------------------------------------------
module decode_monitor #(
    parameter int unsigned STACK_D = 8
) (
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic [13:0] insn_i,
    input  wire logic        insn_valid_i,
    input  wire logic [7:0]  pc_high_latch_i,
    input  wire logic [12:0] pc_o,
    input  wire logic [7:0]  acc_o,
    input  wire logic [7:0]  status_o,
    input  wire logic [7:0]  interrupt_control_reg_o,
    input  wire logic        flush_o
);
    logic busy_ff;                          // refusal cycle after a two-edge word
    logic take, jmp, inc, ret, idle;        // accepted word, by kind
    logic inc_ff;                           // increment taken on the last edge
    assign take = insn_valid_i && !busy_ff;
    assign jmp  = take && insn_i[13:12] == 2'h2;
    assign inc  = take && insn_i[13:8] == 6'h0a;
    assign ret  = take && insn_i == 14'h0009;
    assign idle = take && (insn_i & 14'h3f9f) == 14'h0000;
    // track which edge ignores a word
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            busy_ff <= 1'b0;
            inc_ff  <= 1'b0;
        end else begin
            busy_ff <= jmp || ret;
            inc_ff  <= inc;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    property p_jump_pc;
        jmp |=> pc_o == {$past(pc_high_latch_i[4:3]), $past(insn_i[10:0])};
    endproperty
    a_jump_pc: assert property (p_jump_pc) else $error("jump target wrong");
    property p_jump_flush;
        jmp |=> flush_o ##1 !flush_o;
    endproperty
    a_jump_flush: assert property (p_jump_flush) else $error("jump refill wrong");
    property p_jump_flags;
        jmp && !inc_ff |=> $stable(status_o) && $stable(acc_o);
    endproperty
    a_jump_flags: assert property (p_jump_flags) else $error("jump moved flags");
    property p_inc_pc;
        inc |=> pc_o == $past(pc_o) + 13'h0001;
    endproperty
    a_inc_pc: assert property (p_inc_pc) else $error("increment pc wrong");
    property p_inc_dest;
        inc && insn_i[7] |-> ##2 $stable(acc_o);
    endproperty
    a_inc_dest: assert property (p_inc_dest) else $error("file dest hit acc");
    property p_inc_zero;
        inc && !insn_i[7] |-> ##2 status_o[2] == (acc_o == 8'h00);
    endproperty
    a_inc_zero: assert property (p_inc_zero) else $error("zero flag wrong");
    property p_ret;
        ret |=> interrupt_control_reg_o[7] && flush_o;
    endproperty
    a_ret: assert property (p_ret) else $error("return enable wrong");
    property p_idle;
        idle && !inc_ff |=> pc_o == $past(pc_o) + 13'h0001 && $stable(acc_o) && !flush_o;
    endproperty
    a_idle: assert property (p_idle) else $error("idle word changed state");
endmodule
bind branch_increment_return_decode decode_monitor #(.STACK_D(STACK_D)) mon (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .insn_i(insn_i), .insn_valid_i(insn_valid_i),
    .pc_high_latch_i(pc_high_latch_i), .pc_o(pc_o), .acc_o(acc_o), .status_o(status_o),
    .interrupt_control_reg_o(interrupt_control_reg_o), .flush_o(flush_o));
`default_nettype wire

// ### tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
    $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
// ------------------------------------------------------------
// bench: drives words 1 ns after each rising edge
// ------------------------------------------------------------
module tb_top;
    logic        clk_i = 1'b0;
    logic        rst_n_i, insn_valid_i, push_i, flush_o;
    logic [13:0] insn_i;
    logic [12:0] push_pc_i, pc_o, p;
    logic [7:0]  pc_high_latch_i, acc_o, status_o, ictl, peek_data_o, v;
    logic [6:0]  peek_addr_i;
    int          fail_count = 0;
    int          n_checks = 0;
    always #5 clk_i = ~clk_i;
    branch_increment_return_decode dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .insn_i(insn_i),
        .insn_valid_i(insn_valid_i), .pc_high_latch_i(pc_high_latch_i), .push_i(push_i),
        .push_pc_i(push_pc_i), .peek_addr_i(peek_addr_i), .pc_o(pc_o), .acc_o(acc_o),
        .status_o(status_o), .interrupt_control_reg_o(ictl), .flush_o(flush_o),
        .peek_data_o(peek_data_o));
    task automatic step();
        @(posedge clk_i);
        #1;
    endtask
    task automatic issue(input logic [13:0] w);
        insn_i = w;
        insn_valid_i = 1'b1;
        step();
        insn_valid_i = 1'b0;
    endtask
    // jumps over latch boundaries, a word held into the refused edge each time
    task automatic t_jump();
        logic [7:0]  lt [3] = '{8'h18, 8'he7, 8'h08};
        logic [13:0] wd [3] = '{14'h2805, 14'h2fff, 14'h2000};
        logic [12:0] ex [3] = '{13'h1805, 13'h07ff, 13'h0800};
        insn_valid_i = 1'b1;
        for (int i = 0; i < 3; i++) begin
            pc_high_latch_i = lt[i];
            insn_i = wd[i];
            step();
            `CHK("jump pc", ex[i], pc_o)
            `CHK("jump flush", 1'b1, flush_o)
            insn_i = 14'h2abc;
            step();
            `CHK("refused pc", ex[i], pc_o)
            `CHK("flush end", 1'b0, flush_o)
        end
        insn_valid_i = 1'b0;
        step();
    endtask
    // count file 5 up to all ones, then wrap it through zero
    task automatic t_inc();
        for (int i = 0; i < 260 && peek_data_o !== 8'hff; i++) begin
            v = peek_data_o;
            p = pc_o;
            issue(14'h0a85);
            `CHK("inc pc", p + 13'h0001, pc_o)
            step();
            step();
            `CHK("inc file", v + 8'h01, peek_data_o)
        end
        `CHK("file full", 8'hff, peek_data_o)
        if (peek_data_o !== 8'hff) stop_test();
        issue(14'h0a05);
        step();
        `CHK("acc wrap", 8'h00, acc_o)
        `CHK("zero set", 1'b1, status_o[2])
        `CHK("file kept", 8'hff, peek_data_o)
        issue(14'h0a85);
        step();
        step();
        `CHK("file wrap", 8'h00, peek_data_o)
        `CHK("acc kept", 8'h00, acc_o)
        `CHK("zero set f", 1'b1, status_o[2])
        issue(14'h0a85);
        step();
        step();
        `CHK("zero clear", 1'b0, status_o[2])
        // three words back to back, two into file 5 and one into the
        // accumulator: no refused edge, the second and third each read the result just written
        p = pc_o;
        insn_valid_i = 1'b1;
        insn_i = 14'h0a85;
        step();
        step();
        insn_i = 14'h0a05;
        step();
        insn_valid_i = 1'b0;
        `CHK("inc burst pc", p + 13'h0003, pc_o)
        step();
        `CHK("inc burst acc", 8'h04, acc_o)
        `CHK("inc burst file", 8'h03, peek_data_o)
        `CHK("inc burst zero", 1'b0, status_o[2])
    endtask
    // push an address, then return from interrupt
    task automatic t_ret();
        `CHK("enable off", 1'b0, ictl[7])
        push_pc_i = 13'h1abc;
        push_i = 1'b1;
        step();
        push_i = 1'b0;
        issue(14'h0009);
        `CHK("ret pc", 13'h1abc, pc_o)
        `CHK("ret enable", 1'b1, ictl[7])
        `CHK("ret flush", 1'b1, flush_o)
        step();
    endtask
    // idle words with every don't-care pattern, back to back
    task automatic t_idle();
        v = acc_o;
        insn_valid_i = 1'b1;
        for (int i = 0; i < 4; i++) begin
            p = pc_o;
            insn_i = {7'h00, i[1:0], 5'h00};
            step();
            `CHK("idle pc", p + 13'h0001, pc_o)
            `CHK("idle flush", 1'b0, flush_o)
        end
        insn_valid_i = 1'b0;
        `CHK("idle acc", v, acc_o)
    endtask
    // reset in mid-run: every output except peek_data_o back to its reset value, then a word runs
    task automatic t_reset();
        rst_n_i = 1'b0;
        step();
        `CHK("rst pc", bird_pkg::PC_RST, pc_o)
        `CHK("rst acc", bird_pkg::ACC_RST, acc_o)
        `CHK("rst status", bird_pkg::STATUS_RST, status_o)
        `CHK("rst ictl", bird_pkg::ICTL_RST, ictl)
        `CHK("rst flush", 1'b0, flush_o)
        step();
        rst_n_i = 1'b1;
        issue(14'h0000);
        `CHK("rst first word", 13'h0001, pc_o)
    endtask
    task automatic stop_test();
        if (fail_count == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        {insn_i, insn_valid_i, pc_high_latch_i, push_i, push_pc_i, rst_n_i} = '0;
        peek_addr_i = 7'h05;
        // file ram powers up unknown: preload file 5 in both copies
        dut.u_ram.mem[5] = 8'hf0;
        dut.u_peek.mem[5] = 8'hf0;
        repeat (10) @(posedge clk_i);
        #1;
        rst_n_i = 1'b1;
        t_jump();
        t_inc();
        t_ret();
        t_idle();
        t_reset();
        stop_test();
    end
endmodule
`default_nettype wire
